// *** logic/ssfo_pkg.sv ***
package ssfo_pkg;

  // data path width of positions, speeds, torque and parameters
  localparam int DW = 32;

  // register byte offsets inside the slave window
  localparam logic [7:0] OFS_HOME_POS = 8'h00;
  localparam logic [7:0] OFS_HOME_WIN = 8'h04;
  localparam logic [7:0] OFS_DEV_WIDTH = 8'h08;
  localparam logic [7:0] OFS_REST_RANGE = 8'h0C;
  localparam logic [7:0] OFS_COIN_RANGE = 8'h10;
  localparam logic [7:0] OFS_JOG_SEL = 8'h14;
  localparam logic [7:0] OFS_JOG_BASE = 8'h18;
  localparam logic [7:0] OFS_MAX_SPEED = 8'h34;
  localparam logic [7:0] OFS_OVL_LEVEL = 8'h38;
  localparam logic [7:0] OFS_CFG = 8'h3C;
  localparam logic [7:0] OFS_FLAGS = 8'h40;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFS_SPEED_CMD = 8'h4C;

  // number of jog speed slots, the first at the base, each further one a word after the previous
  localparam int JOG_COUNT = 7;

  // configuration register fields
  localparam int CFG_WP_BIT = 0;
  localparam int CFG_MODE_LSB = 1;
  localparam int CFG_MODE_W = 3;
  localparam int CFG_EDIT_ASSIGNED_BIT = 4;
  localparam int CFG_W = 5;
  localparam int JOG_SEL_W = 3;

  // reset values
  localparam logic [DW-1:0] PARAM_RST = 32'h0000_0000;
  localparam logic [DW-1:0] MAX_SPEED_RST = 32'h7FFF_FFFF;
  localparam logic [DW-1:0] OVL_LEVEL_RST = 32'hFFFF_FFFF;
  localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // home window values that disable the window check
  localparam logic [DW-1:0] HOME_WIN_OFF = 32'h0000_0000;
  localparam logic [DW-1:0] HOME_WIN_MAX = 32'hFFFF_FFFF;

  // control modes held in the configuration register
  typedef enum logic [2:0] {
    MODE_POS_PULSE = 3'h0,
    MODE_POS_INTR = 3'h1,
    MODE_SPEED = 3'h2,
    MODE_TORQUE = 3'h3,
    MODE_POSITIONING = 3'h4
  } ssfo_mode_t;

  // status flags, bit 7 first
  typedef struct packed {
    logic edit_response;
    logic control_ready;
    logic overload_warning;
    logic torque_limit;
    logic speed_match_flag;
    logic motor_at_rest_flag;
    logic zero_deviation;
    logic homing_done;
  } ssfo_flags_t;

  // sequence input pins, synchronised before use
  typedef struct packed {
    logic main_power_input;
    logic edit_permission_input;
    logic jog_negative_command;
    logic jog_positive_command;
    logic coast_input;
    logic emergency_halt_input;
  } ssfo_seq_t;

endpackage : ssfo_pkg

// *** logic/ssfo_sync2.sv ***
`timescale 1ns/1ps
module ssfo_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // two stages, first read only by second
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule : ssfo_sync2

// *** logic/ssfo_within.sv ***
`timescale 1ns/1ps
module ssfo_within #(
  parameter int W = 32
) (
  // signed operands
  input wire logic signed [W-1:0] a,
  input wire logic signed [W-1:0] b,
  // unsigned tolerance
  input wire logic [W-1:0] width,
  // distance between a and b is at most width
  output logic hit
);

  logic signed [W:0] diff;
  logic [W:0] mag;

  // widened difference so no overflow
  always_comb begin
    diff = {a[W-1], a} - {b[W-1], b};
    mag = diff[W] ? (W+1)'(0) - diff : diff;
    hit = (mag <= {1'b0, width});
  end

endmodule : ssfo_within

// *** logic/ssfo_top.sv ***
`timescale 1ns/1ps
module ssfo_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // sequence input pins
  input wire ssfo_pkg::ssfo_seq_t seq_pins,
  // servo loop values on this clock
  input wire logic signed [ssfo_pkg::DW-1:0] feedback_pos,
  input wire logic signed [ssfo_pkg::DW-1:0] command_pos,
  input wire logic signed [ssfo_pkg::DW-1:0] motor_speed,
  input wire logic signed [ssfo_pkg::DW-1:0] analog_speed_ref,
  input wire logic signed [ssfo_pkg::DW-1:0] output_torque,
  input wire logic [ssfo_pkg::DW-1:0] torque_limit_value,
  input wire logic [ssfo_pkg::DW-1:0] load_factor,
  // sequencing and health from this clock
  input wire logic homing_active,
  input wire logic homing_finished,
  input wire logic position_preset,
  input wire logic manual_operation,
  input wire logic decel_unreachable,
  input wire logic alarm_detected,
  input wire logic cpu_healthy,
  // results
  output ssfo_pkg::ssfo_flags_t status_flags,
  output logic signed [ssfo_pkg::DW-1:0] speed_command,
  output logic irq
);

  localparam int DW = ssfo_pkg::DW;

  // bus state
  logic dp_q, dp_d;
  logic dp_write_q, dp_write_d;
  logic dp_hit_q, dp_hit_d;
  logic [7:0] dp_addr_q, dp_addr_d;
  logic hready_q, hready_d;
  logic [31:0] hrdata_q, hrdata_d;
  // parameter registers
  logic [DW-1:0] home_pos_q, home_pos_d;
  logic [DW-1:0] home_win_q, home_win_d;
  logic [DW-1:0] dev_width_q, dev_width_d;
  logic [DW-1:0] rest_range_q, rest_range_d;
  logic [DW-1:0] coin_range_q, coin_range_d;
  logic [ssfo_pkg::JOG_SEL_W-1:0] jog_sel_q, jog_sel_d;
  logic [DW-1:0] jog_spd_q [ssfo_pkg::JOG_COUNT];
  logic [DW-1:0] jog_spd_d [ssfo_pkg::JOG_COUNT];
  logic [DW-1:0] max_speed_q, max_speed_d;
  logic [DW-1:0] ovl_level_q, ovl_level_d;
  logic [ssfo_pkg::CFG_W-1:0] cfg_q, cfg_d;
  logic [7:0] irq_status_q, irq_status_d;
  logic [7:0] irq_mask_q, irq_mask_d;
  logic irq_q, irq_d;
  // flag state
  ssfo_pkg::ssfo_flags_t flags_q, flags_d;
  logic homed_q, homed_d;
  logic signed [DW-1:0] home_ref_q, home_ref_d;
  logic signed [DW-1:0] speed_cmd_q, speed_cmd_d;
  logic signed [DW-1:0] cmd_raw;
  logic cmd_over;
  logic [7:0] flag_rise;
  ssfo_pkg::ssfo_seq_t seq_s;
  ssfo_pkg::ssfo_mode_t mode;
  logic home_in, dev_in, rest_in, match_in;
  logic home_bypass, pos_mode, match_en, match_block;
  logic [DW-1:0] torque_mag;
  logic bus_take;

  // pin inputs through two flip-flops
  ssfo_sync2 #(
    .W($bits(ssfo_pkg::ssfo_seq_t))
  ) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .d(seq_pins),
    .q(seq_s)
  );

  // decoded configuration
  assign mode = ssfo_pkg::ssfo_mode_t'(cfg_q[ssfo_pkg::CFG_MODE_LSB +: ssfo_pkg::CFG_MODE_W]);
  assign bus_take = hsel && htrans[1] && hready;

  // homing state and reference position
  assign homed_d = homing_active ? 1'b0 : (homing_finished ? 1'b1 : homed_q);
  assign home_ref_d = homing_finished ? feedback_pos :
                      (position_preset ? $signed(home_pos_q) : home_ref_q);
  assign home_bypass = (home_win_q == ssfo_pkg::HOME_WIN_OFF) ||
                       (home_win_q == ssfo_pkg::HOME_WIN_MAX);

  // command speed selection and clamp
  assign cmd_raw = (jog_sel_q == 3'h0) ? analog_speed_ref :
                   $signed(jog_spd_q[jog_sel_q - 3'h1]);
  assign cmd_over = (mode != ssfo_pkg::MODE_POS_PULSE) &&
                    (cmd_raw > $signed(max_speed_q) || cmd_raw < -$signed(max_speed_q));
  assign speed_cmd_d = !cmd_over ? cmd_raw :
                       (cmd_raw[DW-1] ? -$signed(max_speed_q) : $signed(max_speed_q));

  // distance comparators
  ssfo_within #(.W(DW)) u_home (
    .a(feedback_pos),
    .b(home_ref_d),
    .width(home_win_q),
    .hit(home_in)
  );
  ssfo_within #(.W(DW)) u_dev (
    .a(command_pos),
    .b(feedback_pos),
    .width(dev_width_q),
    .hit(dev_in)
  );
  ssfo_within #(.W(DW)) u_rest (
    .a(motor_speed),
    .b('0),
    .width(rest_range_q),
    .hit(rest_in)
  );
  ssfo_within #(.W(DW)) u_match (
    .a(motor_speed),
    .b(speed_cmd_d),
    .width(coin_range_q),
    .hit(match_in)
  );

  // mode qualifiers
  assign pos_mode = (mode == ssfo_pkg::MODE_POS_PULSE) || (mode == ssfo_pkg::MODE_POS_INTR) ||
                    (mode == ssfo_pkg::MODE_POSITIONING);
  assign match_en = (mode != ssfo_pkg::MODE_TORQUE) &&
                    ((mode == ssfo_pkg::MODE_SPEED) || (mode == ssfo_pkg::MODE_POS_INTR) ||
                     homing_active);
  assign match_block = manual_operation &&
                       ((!seq_s.jog_positive_command && !seq_s.jog_negative_command) ||
                        cmd_over || decel_unreachable);
  assign torque_mag = output_torque[DW-1] ? DW'(-output_torque) : output_torque;

  // next status flags, recomputed every cycle
  always_comb begin
    flags_d = flags_q;
    flags_d.homing_done = homed_d && (home_bypass || home_in);
    flags_d.zero_deviation = pos_mode ? dev_in : flags_q.zero_deviation;
    flags_d.motor_at_rest_flag = rest_in;
    flags_d.speed_match_flag = match_en && !match_block && match_in;
    flags_d.torque_limit = (torque_mag == torque_limit_value);
    flags_d.overload_warning = (load_factor >= ovl_level_q);
    flags_d.control_ready = seq_s.emergency_halt_input && !seq_s.coast_input &&
                            !alarm_detected && cpu_healthy && seq_s.main_power_input;
    flags_d.edit_response = !cfg_q[ssfo_pkg::CFG_WP_BIT] &&
                            (!cfg_q[ssfo_pkg::CFG_EDIT_ASSIGNED_BIT] ||
                             seq_s.edit_permission_input);
    flag_rise = flags_d & ~flags_q;
  end

  // flag and homing registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= ssfo_pkg::FLAGS_RST;
      homed_q <= 1'b0;
      home_ref_q <= '0;
      speed_cmd_q <= '0;
    end else begin
      flags_q <= flags_d;
      homed_q <= homed_d;
      home_ref_q <= home_ref_d;
      speed_cmd_q <= speed_cmd_d;
    end
  end

  // bus slave, register writes, read mux, interrupt
  always_comb begin
    logic [31:0] rd;
    logic [7:0] clr;
    rd = 32'h0000_0000;
    clr = 8'h00;
    dp_d = dp_q;
    dp_write_d = dp_write_q;
    dp_hit_d = dp_hit_q;
    dp_addr_d = dp_addr_q;
    hready_d = hready_q;
    hrdata_d = hrdata_q;
    home_pos_d = home_pos_q;
    home_win_d = home_win_q;
    dev_width_d = dev_width_q;
    rest_range_d = rest_range_q;
    coin_range_d = coin_range_q;
    jog_sel_d = jog_sel_q;
    jog_spd_d = jog_spd_q;
    max_speed_d = max_speed_q;
    ovl_level_d = ovl_level_q;
    cfg_d = cfg_q;
    irq_mask_d = irq_mask_q;
    unique case (dp_addr_q)
      ssfo_pkg::OFS_HOME_POS: rd = home_pos_q;
      ssfo_pkg::OFS_HOME_WIN: rd = home_win_q;
      ssfo_pkg::OFS_DEV_WIDTH: rd = dev_width_q;
      ssfo_pkg::OFS_REST_RANGE: rd = rest_range_q;
      ssfo_pkg::OFS_COIN_RANGE: rd = coin_range_q;
      ssfo_pkg::OFS_JOG_SEL: rd = {29'h0000_0000, jog_sel_q};
      ssfo_pkg::OFS_MAX_SPEED: rd = max_speed_q;
      ssfo_pkg::OFS_OVL_LEVEL: rd = ovl_level_q;
      ssfo_pkg::OFS_CFG: rd = {27'h0000_0000, cfg_q};
      ssfo_pkg::OFS_FLAGS: rd = {24'h00_0000, flags_q};
      ssfo_pkg::OFS_IRQ_STATUS: rd = {24'h00_0000, irq_status_q};
      ssfo_pkg::OFS_IRQ_MASK: rd = {24'h00_0000, irq_mask_q};
      ssfo_pkg::OFS_SPEED_CMD: rd = speed_cmd_q;
      default: rd = 32'h0000_0000;
    endcase
    for (int i = 0; i < ssfo_pkg::JOG_COUNT; i++) begin
      if (dp_addr_q == ssfo_pkg::OFS_JOG_BASE + 8'(4 * i)) begin
        rd = jog_spd_q[i];
      end
    end
    if (dp_q && !hready_q) begin
      // first data cycle, the wait state: commit write or return read
      hready_d = 1'b1;
      dp_d = 1'b0;
      if (!dp_write_q) begin
        hrdata_d = dp_hit_q ? rd : 32'h0000_0000;
      end else if (dp_hit_q) begin
        unique case (dp_addr_q)
          ssfo_pkg::OFS_HOME_POS: home_pos_d = hwdata;
          ssfo_pkg::OFS_HOME_WIN: home_win_d = hwdata;
          ssfo_pkg::OFS_DEV_WIDTH: dev_width_d = hwdata;
          ssfo_pkg::OFS_REST_RANGE: rest_range_d = hwdata;
          ssfo_pkg::OFS_COIN_RANGE: coin_range_d = hwdata;
          ssfo_pkg::OFS_JOG_SEL: jog_sel_d = hwdata[ssfo_pkg::JOG_SEL_W-1:0];
          ssfo_pkg::OFS_MAX_SPEED: max_speed_d = hwdata;
          ssfo_pkg::OFS_OVL_LEVEL: ovl_level_d = hwdata;
          ssfo_pkg::OFS_CFG: cfg_d = hwdata[ssfo_pkg::CFG_W-1:0];
          ssfo_pkg::OFS_IRQ_STATUS: clr = hwdata[7:0];
          ssfo_pkg::OFS_IRQ_MASK: irq_mask_d = hwdata[7:0];
          default: clr = 8'h00;
        endcase
        for (int i = 0; i < ssfo_pkg::JOG_COUNT; i++) begin
          if (dp_addr_q == ssfo_pkg::OFS_JOG_BASE + 8'(4 * i)) begin
            jog_spd_d[i] = hwdata;
          end
        end
      end
    end else if (bus_take) begin
      // address phase taken, one wait state follows
      dp_d = 1'b1;
      hready_d = 1'b0;
      dp_write_d = hwrite;
      dp_addr_d = haddr[7:0];
      dp_hit_d = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
    end
    irq_status_d = (irq_status_q & ~clr) | flag_rise;
    irq_d = |(irq_status_d & irq_mask_d);
  end

  // bus and register file flip-flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dp_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_hit_q <= 1'b0;
      dp_addr_q <= 8'h00;
      hready_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
      home_pos_q <= ssfo_pkg::PARAM_RST;
      home_win_q <= ssfo_pkg::PARAM_RST;
      dev_width_q <= ssfo_pkg::PARAM_RST;
      rest_range_q <= ssfo_pkg::PARAM_RST;
      coin_range_q <= ssfo_pkg::PARAM_RST;
      jog_sel_q <= 3'h0;
      for (int i = 0; i < ssfo_pkg::JOG_COUNT; i++) begin
        jog_spd_q[i] <= ssfo_pkg::PARAM_RST;
      end
      max_speed_q <= ssfo_pkg::MAX_SPEED_RST;
      ovl_level_q <= ssfo_pkg::OVL_LEVEL_RST;
      cfg_q <= ssfo_pkg::CFG_RST;
      irq_status_q <= 8'h00;
      irq_mask_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      dp_q <= dp_d;
      dp_write_q <= dp_write_d;
      dp_hit_q <= dp_hit_d;
      dp_addr_q <= dp_addr_d;
      hready_q <= hready_d;
      hrdata_q <= hrdata_d;
      home_pos_q <= home_pos_d;
      home_win_q <= home_win_d;
      dev_width_q <= dev_width_d;
      rest_range_q <= rest_range_d;
      coin_range_q <= coin_range_d;
      jog_sel_q <= jog_sel_d;
      jog_spd_q <= jog_spd_d;
      max_speed_q <= max_speed_d;
      ovl_level_q <= ovl_level_d;
      cfg_q <= cfg_d;
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
    end
  end

  // outputs straight from flip-flops, hresp tied low
  assign hreadyout = hready_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign status_flags = flags_q;
  assign speed_command = speed_cmd_q;
  assign irq = irq_q;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  chk_homing_bypass: assert property (
    homing_finished && !homing_active && home_bypass |=> flags_q.homing_done
  ) else $error("homing done not set with window disabled");

  chk_homing_window: assert property (
    homed_q && !home_bypass && !home_in && !homing_finished && !position_preset
    |=> !flags_q.homing_done
  ) else $error("homing done held outside home window");

  chk_home_ref: assert property (
    homing_finished |=> home_ref_q == $past(feedback_pos)
  ) else $error("home reference not the homing stop point");

  chk_dev_freeze: assert property (
    mode == ssfo_pkg::MODE_TORQUE |=> $stable(flags_q.zero_deviation)
  ) else $error("zero deviation changed outside position control");

  chk_torque_match: assert property (
    mode == ssfo_pkg::MODE_TORQUE |=> !flags_q.speed_match_flag
  ) else $error("speed match set under torque control");

  chk_manual_nojog: assert property (
    manual_operation && !seq_s.jog_positive_command && !seq_s.jog_negative_command
    |=> !flags_q.speed_match_flag
  ) else $error("speed match set with no jog command");

  chk_speed_clamp: assert property (
    mode != ssfo_pkg::MODE_POS_PULSE
    |=> speed_cmd_q <= $signed($past(max_speed_q)) &&
        speed_cmd_q >= -$signed($past(max_speed_q))
  ) else $error("speed command above maximum");

  chk_torque_flag: assert property (
    torque_mag == torque_limit_value |=> flags_q.torque_limit
  ) else $error("torque limit flag missing at limit");

  chk_overload: assert property (
    ##1 flags_q.overload_warning == ($past(load_factor) >= $past(ovl_level_q))
  ) else $error("overload flag disagrees with load level");

  chk_ready_pins: assert property (
    flags_q.control_ready |-> $past(seq_pins.emergency_halt_input, 3) &&
                              !$past(seq_pins.coast_input, 3)
  ) else $error("ready set without halt on and coast off");

  chk_edit_protect: assert property (
    cfg_q[ssfo_pkg::CFG_WP_BIT] |=> !flags_q.edit_response
  ) else $error("edit response set under write protect");

endmodule : ssfo_top

// *** verif/ssfo_host_model.sv ***
`timescale 1ns/1ps
module ssfo_host_model (
  // clock
  input wire logic ref_clk,
  // amplifier flags and the routing code of one terminal
  input wire ssfo_pkg::ssfo_flags_t status_flags,
  input wire logic [5:0] func_code,
  // terminal level as the host samples it
  output logic term_q
);
  logic term_d;

  // route the flag picked by its function code, off when unmapped
  always_comb begin
    term_d = 1'b0;
    if (func_code >= 6'h16 && func_code <= 6'h1D) begin
      term_d = status_flags[3'(func_code - 6'h16)];
    end
  end

  // host samples the terminal on every rising edge
  always_ff @(posedge ref_clk) begin
    term_q <= term_d;
  end
endmodule : ssfo_host_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic arst_n, hsel, hwrite, hready, hreadyout, hresp, irq, term;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, torque_limit_value, load_factor;
  logic [5:0] func_code;
  ssfo_pkg::ssfo_seq_t seq_pins;
  ssfo_pkg::ssfo_flags_t status_flags;
  logic signed [31:0] feedback_pos, command_pos, motor_speed, analog_speed_ref;
  logic signed [31:0] output_torque, speed_command;
  logic homing_active, homing_finished, position_preset, manual_operation;
  logic decel_unreachable, alarm_detected, cpu_healthy;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  int sv[5] = '{-10, 10, 11, -11, 0};
  int zm[7] = '{0, 0, 3, 2, 1, 3, 4};
  int zf[7] = '{95, 94, 100, 100, 100, 80, 80};
  int hf[4] = '{1010, 1011, 990, 989};

  // single slave: its ready is the bus ready
  assign hready = hreadyout;
  always #4 ref_clk = ~ref_clk;

  // device under test and the host at the terminals
  ssfo_top uut (
    .ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .seq_pins, .feedback_pos, .command_pos, .motor_speed,
    .analog_speed_ref, .output_torque, .torque_limit_value, .load_factor, .homing_active,
    .homing_finished, .position_preset, .manual_operation, .decel_unreachable,
    .alarm_detected, .cpu_healthy, .status_flags, .speed_command, .irq
  );
  ssfo_host_model host (.ref_clk, .status_flags, .func_code, .term_q(term));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic g, input logic e);
    cmp_word({31'h0, g}, {31'h0, e});
  endtask : cmp_bit

  // one ahb-lite single transfer, one address then one data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    cmp_word(x, e);
  endtask : rdc

  task automatic setcfg(input logic [2:0] m);
    wr(ssfo_pkg::OFS_CFG, {27'h0, 1'b0, m, 1'b0});
  endtask : setcfg

  // long enough for pin synchronisers plus the flag register
  task automatic wt();
    repeat (4) @(posedge ref_clk);
  endtask : wt

  task automatic mchk(input logic [2:0] m, input logic e);
    setcfg(m);
    wt();
    cmp_bit(status_flags.speed_match_flag, e);
  endtask : mchk

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend

  // main sequence
  initial begin
    arst_n <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= 32'h0;
    func_code <= 6'h00;
    seq_pins <= 6'h00;
    {feedback_pos, command_pos, motor_speed, analog_speed_ref} <= 128'h0;
    {output_torque, torque_limit_value, load_factor} <= 96'h0;
    {homing_active, homing_finished, position_preset, manual_operation} <= 4'h0;
    {decel_unreachable, alarm_detected, cpu_healthy} <= 3'h1;
    repeat (5) @(posedge ref_clk);
    cmp_word({24'h0, status_flags}, 32'h0);
    cmp_bit(irq, 1'b0);
    arst_n <= 1'b1;
    rdc(ssfo_pkg::OFS_MAX_SPEED, 32'h7FFF_FFFF);
    rdc(ssfo_pkg::OFS_OVL_LEVEL, 32'hFFFF_FFFF);
    wr(8'h50, 32'hFFFF_FFFF);
    rdc(8'h50, 32'h0);
    cmp_bit(hresp, 1'b0);
    tend("reset");
    for (int i = 5; i >= 0; i--) begin
      seq_pins.emergency_halt_input <= (i != 1);
      seq_pins.coast_input <= (i == 2);
      seq_pins.main_power_input <= (i != 3);
      alarm_detected <= (i == 4);
      cpu_healthy <= (i != 5);
      wt();
      cmp_bit(status_flags.control_ready, i == 0);
    end
    tend("ready");
    for (int i = 0; i < 8; i++) begin
      wr(ssfo_pkg::OFS_CFG, {27'h0, i[1], 3'h0, i[0]});
      seq_pins.edit_permission_input <= i[2];
      wt();
      cmp_bit(status_flags.edit_response, !i[0] && (!i[1] || i[2]));
    end
    tend("edit");
    wr(ssfo_pkg::OFS_REST_RANGE, 32'h0000_000A);
    torque_limit_value <= 32'h0000_000A;
    for (int i = 0; i < 5; i++) begin
      motor_speed <= sv[i];
      output_torque <= sv[i];
      wt();
      cmp_bit(status_flags.motor_at_rest_flag, i < 2 || i == 4);
      cmp_bit(status_flags.torque_limit, i < 2);
    end
    tend("rest and torque");
    wr(ssfo_pkg::OFS_OVL_LEVEL, 32'h0000_0064);
    wr(ssfo_pkg::OFS_IRQ_MASK, 32'h0000_0020);
    wr(ssfo_pkg::OFS_IRQ_STATUS, 32'h0000_00FF);
    for (int i = 0; i < 4; i++) begin
      load_factor <= 32'(99 + (i % 3));
      wt();
      cmp_bit(status_flags.overload_warning, i == 1 || i == 2);
      cmp_bit(irq, i > 0);
    end
    rdc(ssfo_pkg::OFS_IRQ_STATUS, 32'h0000_0020);
    wr(ssfo_pkg::OFS_IRQ_STATUS, 32'h0000_0020);
    wt();
    cmp_bit(irq, 1'b0);
    wr(ssfo_pkg::OFS_IRQ_MASK, 32'h0);
    load_factor <= 32'h0000_0064;
    wt();
    cmp_bit(irq, 1'b0);
    rdc(ssfo_pkg::OFS_IRQ_STATUS, 32'h0000_0020);
    tend("overload");
    wr(ssfo_pkg::OFS_DEV_WIDTH, 32'h0000_0005);
    command_pos <= 32'sd100;
    for (int i = 0; i < 7; i++) begin
      setcfg(zm[i][2:0]);
      feedback_pos <= zf[i];
      wt();
      cmp_bit(status_flags.zero_deviation, i == 0 || i == 4 || i == 5);
    end
    tend("deviation");
    wr(ssfo_pkg::OFS_COIN_RANGE, 32'h0000_0003);
    wr(ssfo_pkg::OFS_JOG_SEL, 32'h0000_0002);
    wr(ssfo_pkg::OFS_JOG_BASE + 8'h04, 32'h0000_00C8);
    motor_speed <= 32'sd198;
    analog_speed_ref <= 32'sd500;
    mchk(3'h2, 1'b1);
    cmp_word(speed_command, 32'h0000_00C8);
    mchk(3'h3, 1'b0);
    mchk(3'h0, 1'b0);
    homing_active <= 1'b1;
    mchk(3'h0, 1'b1);
    homing_active <= 1'b0;
    mchk(3'h1, 1'b1);
    mchk(3'h4, 1'b0);
    wr(ssfo_pkg::OFS_JOG_SEL, 32'h0);
    motor_speed <= 32'sd500;
    mchk(3'h2, 1'b1);
    cmp_word(speed_command, 32'h0000_01F4);
    wr(ssfo_pkg::OFS_MAX_SPEED, 32'h0000_012C);
    mchk(3'h2, 1'b0);
    cmp_word(speed_command, 32'h0000_012C);
    mchk(3'h0, 1'b0);
    cmp_word(speed_command, 32'h0000_01F4);
    analog_speed_ref <= 32'sd250;
    motor_speed <= 32'sd250;
    manual_operation <= 1'b1;
    mchk(3'h2, 1'b0);
    seq_pins.jog_positive_command <= 1'b1;
    mchk(3'h2, 1'b1);
    decel_unreachable <= 1'b1;
    mchk(3'h2, 1'b0);
    decel_unreachable <= 1'b0;
    seq_pins.jog_positive_command <= 1'b0;
    seq_pins.jog_negative_command <= 1'b1;
    wr(ssfo_pkg::OFS_MAX_SPEED, 32'h0000_00C8);
    motor_speed <= 32'sd200;
    mchk(3'h2, 1'b0);
    manual_operation <= 1'b0;
    mchk(3'h2, 1'b1);
    tend("speed match");
    wr(ssfo_pkg::OFS_HOME_WIN, 32'h0000_000A);
    feedback_pos <= 32'sd1000;
    wt();
    cmp_bit(status_flags.homing_done, 1'b0);
    homing_active <= 1'b1;
    @(posedge ref_clk);
    homing_active <= 1'b0;
    homing_finished <= 1'b1;
    @(posedge ref_clk);
    homing_finished <= 1'b0;
    wt();
    cmp_bit(status_flags.homing_done, 1'b1);
    for (int i = 0; i < 4; i++) begin
      feedback_pos <= hf[i];
      wt();
      cmp_bit(status_flags.homing_done, !i[0]);
    end
    wr(ssfo_pkg::OFS_HOME_POS, 32'h0000_1388);
    feedback_pos <= 32'sd5000;
    position_preset <= 1'b1;
    @(posedge ref_clk);
    position_preset <= 1'b0;
    wt();
    cmp_bit(status_flags.homing_done, 1'b1);
    feedback_pos <= 32'sd1000;
    wt();
    cmp_bit(status_flags.homing_done, 1'b0);
    wr(ssfo_pkg::OFS_HOME_WIN, 32'h0);
    wt();
    cmp_bit(status_flags.homing_done, 1'b1);
    wr(ssfo_pkg::OFS_HOME_WIN, 32'hFFFF_FFFF);
    wt();
    cmp_bit(status_flags.homing_done, 1'b1);
    homing_active <= 1'b1;
    wt();
    cmp_bit(status_flags.homing_done, 1'b0);
    homing_active <= 1'b0;
    homing_finished <= 1'b1;
    @(posedge ref_clk);
    homing_finished <= 1'b0;
    feedback_pos <= 32'sd9000;
    wt();
    cmp_bit(status_flags.homing_done, 1'b1);
    tend("homing");
    for (int c = 22; c < 30; c++) begin
      func_code <= 6'(c);
      wt();
      cmp_bit(term, status_flags[c - 22]);
    end
    tend("routing");
    final_report();
  end
endmodule : tb_top
